//--- srr_pkg.sv
// constants for the subroutine return and rotate-through-carry executor
// assumes a core that presents one instruction word per four-phase cycle
package srr_pkg;

  localparam logic [15:0] SRR_RET_MASK   = 16'hFFFE;
  localparam logic [15:0] SRR_RET_CODE   = 16'h0012;
  localparam logic [15:0] SRR_ROT_MASK   = 16'hFC00;
  localparam logic [15:0] SRR_ROT_CODE   = 16'h3400;
  localparam int          SRR_SHADOW_BIT = 0;
  localparam int          SRR_DEST_BIT   = 9;
  localparam int          SRR_ACC_BIT    = 8;
  localparam logic [7:0]  SRR_ACC_SPLIT  = 8'h5F;
  localparam logic [3:0]  SRR_ACC_HI_BNK = 4'hF;
  localparam logic [3:0]  SRR_ACC_LO_BNK = 4'h0;
  localparam int          SRR_FLAG_C     = 0;
  localparam int          SRR_FLAG_Z     = 2;
  localparam int          SRR_FLAG_N     = 4;
  localparam logic [1:0]  SRR_Q1         = 2'h0;
  localparam logic [1:0]  SRR_Q2         = 2'h1;
  localparam logic [1:0]  SRR_Q3         = 2'h2;
  localparam logic [1:0]  SRR_Q4         = 2'h3;
  localparam logic [7:0]  SRR_RST_BYTE   = 8'h00;
  localparam logic [20:0] SRR_RST_PC     = 21'h00_0000;

  typedef enum logic [1:0] {
    SRR_ST_IDLE,
    SRR_ST_ROT,
    SRR_ST_RET,
    SRR_ST_FLUSH
  } srr_state_t;

endpackage : srr_pkg

//--- srr_core.sv
// execution of subroutine return and rotate-left-through-carry
// assumes instruction memory, return stack and file memory sit outside,
// all synchronous to mclk; one instruction cycle is four mclk phases
`timescale 1ns/100ps
module srr_core
  import srr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [15:0] instr_word,
  input  wire logic        instr_valid,
  input  wire logic        ext_set_en,
  input  wire logic [20:0] stack_top,
  input  wire logic [11:0] indexed_base,
  input  wire logic [7:0]  shadow_working,
  input  wire logic [7:0]  shadow_flags,
  input  wire logic [7:0]  shadow_bank_select,
  input  wire logic [7:0]  file_rdata,
  output logic [1:0]       q_phase,
  output logic [11:0]      file_addr,
  output logic             file_rd,
  output logic             file_wr,
  output logic [7:0]       file_wdata,
  output logic             stack_pop,
  output logic [20:0]      pc,
  output logic [7:0]       working,
  output logic [7:0]       flags,
  output logic [7:0]       bank_select_register,
  output logic             flush
);

  logic [1:0]  phase_reg;
  srr_state_t  st_reg;
  srr_state_t  st_next;
  logic        dest_reg;
  logic        shadow_reg;
  logic [11:0] addr_reg;
  logic [11:0] addr_next;
  logic [7:0]  operand_reg;
  logic [7:0]  result_reg;
  logic        cout_reg;
  logic [20:0] pc_reg;
  logic [7:0]  working_reg;
  logic [7:0]  flags_reg;
  logic [7:0]  bsr_reg;
  logic [7:0]  working_next;
  logic [7:0]  flags_next;
  logic [7:0]  bsr_next;

  // decode of the presented word
  wire        is_ret    = (instr_word & SRR_RET_MASK) == SRR_RET_CODE;
  wire        is_rot    = (instr_word & SRR_ROT_MASK) == SRR_ROT_CODE;
  wire [7:0]  f_field   = instr_word[7:0];
  wire        acc_bit   = instr_word[SRR_ACC_BIT];
  wire        low_part  = f_field <= SRR_ACC_SPLIT;
  wire        indexed   = ext_set_en && !acc_bit && low_part;
  wire        take      = (phase_reg == SRR_Q1) && (st_reg == SRR_ST_IDLE)
                          && instr_valid;
  wire        end_cycle = phase_reg == SRR_Q4;

  // phase strobes of the current instruction
  wire in_q2  = phase_reg == SRR_Q2;
  wire in_q3  = phase_reg == SRR_Q3;
  wire in_q4  = phase_reg == SRR_Q4;
  wire rot_q4 = in_q4 && (st_reg == SRR_ST_ROT);
  wire ret_q4 = in_q4 && (st_reg == SRR_ST_RET);

  // rotated byte; carry in is the flag as it stands in Q3, safe because
  // only one instruction is in flight at a time
  wire [7:0] rot_value = {operand_reg[6:0], flags_reg[SRR_FLAG_C]};
  wire       rot_zero  = result_reg == 8'h00;
  wire       rot_neg   = result_reg[7];
  wire [7:0] flags_rot;

  // per-bit flag update: carry, zero and negative follow the result,
  // every other flag bit keeps its value
  generate
    for (genvar fb = 0; fb < 8; fb = fb + 1) begin : g_flag
      if (fb == SRR_FLAG_C) begin : g_carry
        assign flags_rot[fb] = cout_reg;
      end else if (fb == SRR_FLAG_Z) begin : g_zero
        assign flags_rot[fb] = rot_zero;
      end else if (fb == SRR_FLAG_N) begin : g_neg
        assign flags_rot[fb] = rot_neg;
      end else begin : g_keep
        assign flags_rot[fb] = flags_reg[fb];
      end
    end
  endgenerate

  // file address selection
  always_comb begin
    if (indexed) begin
      addr_next = indexed_base + {4'h0, f_field};
    end else if (acc_bit) begin
      addr_next = {bsr_reg[3:0], f_field};
    end else if (low_part) begin
      addr_next = {SRR_ACC_LO_BNK, f_field};
    end else begin
      addr_next = {SRR_ACC_HI_BNK, f_field};
    end
  end

  // state sequencing across instruction cycles
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      SRR_ST_IDLE: begin
        if (take && is_ret) begin
          st_next = SRR_ST_RET;
        end else if (take && is_rot) begin
          st_next = SRR_ST_ROT;
        end
      end
      SRR_ST_ROT: begin
        if (end_cycle) st_next = SRR_ST_IDLE;
      end
      SRR_ST_RET: begin
        if (end_cycle) st_next = SRR_ST_FLUSH;
      end
      SRR_ST_FLUSH: begin
        if (end_cycle) st_next = SRR_ST_IDLE;
      end
      default: st_next = SRR_ST_IDLE;
    endcase
  end

  // phase divider and state
  always_ff @(posedge mclk) begin
    if (rst) begin
      phase_reg <= SRR_Q1;
      st_reg    <= SRR_ST_IDLE;
    end else begin
      phase_reg <= phase_reg + 2'h1;
      st_reg    <= st_next;
    end
  end

  // instruction fields caught at decode
  always_ff @(posedge mclk) begin
    if (rst) begin
      dest_reg   <= 1'b0;
      shadow_reg <= 1'b0;
      addr_reg   <= 12'h000;
    end else if (take) begin
      dest_reg   <= instr_word[SRR_DEST_BIT];
      shadow_reg <= instr_word[SRR_SHADOW_BIT];
      addr_reg   <= addr_next;
    end
  end

  // read in phase two, compute in phase three
  always_ff @(posedge mclk) begin
    if (rst) begin
      operand_reg <= SRR_RST_BYTE;
      result_reg  <= SRR_RST_BYTE;
      cout_reg    <= 1'b0;
    end else if (in_q2 && st_reg == SRR_ST_ROT) begin
      operand_reg <= file_rdata;
    end else if (in_q3 && st_reg == SRR_ST_ROT) begin
      result_reg <= rot_value;
      cout_reg   <= operand_reg[7];
    end
  end

  // program counter loads only from the popped stack top
  always_ff @(posedge mclk) begin
    if (rst) begin
      pc_reg <= SRR_RST_PC;
    end else if (ret_q4) begin
      pc_reg <= stack_top;
    end
  end

  // next values of working, flags and bank select in phase four; a
  // return with the shadow bit clear falls through to the hold branch,
  // so none of the three moves
  wire load_shadow = ret_q4 && shadow_reg;
  wire load_work   = rot_q4 && !dest_reg;
  assign working_next = load_shadow ? shadow_working
                      : load_work   ? result_reg
                      : working_reg;
  assign flags_next   = load_shadow ? shadow_flags
                      : rot_q4      ? flags_rot
                      : flags_reg;
  assign bsr_next     = load_shadow ? shadow_bank_select
                      : bsr_reg;

  // working register
  always_ff @(posedge mclk) begin
    if (rst) begin
      working_reg <= SRR_RST_BYTE;
    end else begin
      working_reg <= working_next;
    end
  end

  // flags register
  always_ff @(posedge mclk) begin
    if (rst) begin
      flags_reg <= SRR_RST_BYTE;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // bank select register
  always_ff @(posedge mclk) begin
    if (rst) begin
      bsr_reg <= SRR_RST_BYTE;
    end else begin
      bsr_reg <= bsr_next;
    end
  end

  // handshake strobes; return without shadow leaves the registers alone
  assign file_rd   = in_q2 && (st_reg == SRR_ST_ROT);
  assign file_wr   = rot_q4 && dest_reg;
  assign stack_pop = ret_q4;
  assign flush     = st_reg == SRR_ST_FLUSH;

  // registered data outputs
  assign q_phase              = phase_reg;
  assign file_addr            = addr_reg;
  assign file_wdata           = result_reg;
  assign pc                   = pc_reg;
  assign working              = working_reg;
  assign flags                = flags_reg;
  assign bank_select_register = bsr_reg;

endmodule : srr_core

//--- srr_core_props.sv
// timing and value checks on the srr_core ports
// assumes a bind onto srr_core; rst is synchronous and active high
`timescale 1ns/100ps
module srr_core_props (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [20:0] stack_top,
  input wire logic [7:0]  file_rdata,
  input wire logic [1:0]  q_phase,
  input wire logic        file_rd,
  input wire logic        file_wr,
  input wire logic [7:0]  file_wdata,
  input wire logic        stack_pop,
  input wire logic [20:0] pc,
  input wire logic [7:0]  flags,
  input wire logic        flush
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // strobes sit in their fixed phases
  AST_RD_Q2:
    assert property (file_rd |-> q_phase == 2'h1) else $error("rd phase");
  AST_WR_Q4:
    assert property (file_wr |-> q_phase == 2'h3) else $error("wr phase");
  AST_POP_Q4:
    assert property (stack_pop |-> q_phase == 2'h3) else $error("pop phase");
  // program counter moves only on a pop, to the stack top
  AST_PC_POP:
    assert property (stack_pop |=> pc == $past(stack_top)) else $error("pc");
  AST_PC_HOLD:
    assert property (!stack_pop |=> $stable(pc)) else $error("pc moved");
  AST_FLUSH:
    assert property (stack_pop |=> flush [*4]) else $error("flush");
  // rotated byte and carry follow the byte read two edges earlier
  AST_WDATA:
    assert property (file_wr |-> file_wdata ==
      {$past(file_rdata[6:0], 2), flags[0]}) else $error("wdata");
  AST_CARRY:
    assert property (file_wr |=> flags[0] == $past(file_rdata[7], 3))
    else $error("carry");
endmodule : srr_core_props

//--- srr_core_tb_top.sv
// random mix of rotates and returns on srr_core, queued expectations
// assumes srr_pkg, srr_core and srr_core_props are compiled first
`timescale 1ns/100ps
module srr_core_tb_top;
  import srr_pkg::*;
  typedef struct {logic d; logic [11:0] a; logic [7:0] v, w, f, b;
    logic [20:0] p;} srr_note_t;
  logic        mclk, rst, instr_valid, ext_set_en;
  logic        file_rd, file_wr, stack_pop, flush;
  logic [1:0]  q_phase;
  logic [15:0] instr_word;
  logic [20:0] stack_top, pc;
  logic [11:0] indexed_base, file_addr;
  logic [7:0]  shadow_working, shadow_flags, shadow_bank_select, file_rdata;
  logic [7:0]  file_wdata, working, flags, bank_select_register;
  logic [7:0]  w = 0, f = 0, b = 0, res, fa;
  int          error_cnt = 0, checks_done = 0, cyc = 0;
  srr_note_t   nq[$], n, m;
  srr_core i_dut (
    .mclk                 (mclk),
    .rst                  (rst),
    .instr_word           (instr_word),
    .instr_valid          (instr_valid),
    .ext_set_en           (ext_set_en),
    .stack_top            (stack_top),
    .indexed_base         (indexed_base),
    .shadow_working       (shadow_working),
    .shadow_flags         (shadow_flags),
    .shadow_bank_select   (shadow_bank_select),
    .file_rdata           (file_rdata),
    .q_phase              (q_phase),
    .file_addr            (file_addr),
    .file_rd              (file_rd),
    .file_wr              (file_wr),
    .file_wdata           (file_wdata),
    .stack_pop            (stack_pop),
    .pc                   (pc),
    .working              (working),
    .flags                (flags),
    .bank_select_register (bank_select_register),
    .flush                (flush)
  );
  // clock
  initial begin
    mclk = 0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(string nm, logic [20:0] e, logic [20:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 1500) begin
      error_cnt++;
      end_sim();
    end
  end
  // take the oldest note whenever a strobe shows a result
  initial forever begin
    @(negedge mclk);
    #1;
    if (file_rd === 1'b1) begin
      n = nq.pop_front();
      chk("addr", 21'(n.a), 21'(file_addr));
      chk("rd phase", 21'(SRR_Q2), 21'(q_phase));
      repeat (2) @(negedge mclk);
      #1;
      chk("wr", 21'(n.d), 21'(file_wr));
      if (n.d) chk("wdata", 21'(n.v), 21'(file_wdata));
      @(negedge mclk);
      #1;
      chk("w", 21'(n.w), 21'(working));
      chk("flags", 21'(n.f), 21'(flags));
    end else if (stack_pop === 1'b1) begin
      n = nq.pop_front();
      chk("pop phase", 21'(SRR_Q4), 21'(q_phase));
      @(negedge mclk);
      #1;
      chk("pc", n.p, pc);
      chk("w", 21'(n.w), 21'(working));
      chk("flags", 21'(n.f), 21'(flags));
      chk("bank", 21'(n.b), 21'(bank_select_register));
      chk("flush", 21'(1'b1), 21'(flush));
    end
  end
  // drive instructions at Q1 and note what each should produce
  initial begin
    {rst, instr_valid, ext_set_en, instr_word, stack_top} = '0;
    {indexed_base, shadow_working, shadow_flags} = '0;
    {shadow_bank_select, file_rdata} = '0;
    rst = 1;
    void'($urandom(32'hc8b2));
    repeat (16) @(negedge mclk);
    rst = 0;
    for (int i = 0; i < 60; i++) begin
      do @(negedge mclk); while (q_phase !== 2'h0 || flush !== 1'b0);
      {shadow_working, shadow_flags, shadow_bank_select, file_rdata} =
        $urandom;
      {stack_top, indexed_base[10:0]} = $urandom;
      ext_set_en = i[1];
      if (i == 0) file_rdata = 8'h00;
      instr_word = (i % 3 == 2) ? {15'h0009, i[2]} : {6'h0d, 10'($urandom)};
      fa = instr_word[7:0];
      if (i % 3 != 2) begin
        res = {file_rdata[6:0], f[0]};
        m.a = instr_word[8] ? {b[3:0], fa} : (ext_set_en && fa <= 8'h5f)
          ? indexed_base + 12'(fa) : {(fa > 8'h5f) ? 4'hf : 4'h0, fa};
        f[0] = file_rdata[7];
        f[2] = (res == 8'h00);
        f[4] = res[7];
        if (!instr_word[9]) w = res;
        m.d = instr_word[9];
        m.v = res;
      end else if (instr_word[0]) begin
        {w, f, b} = {shadow_working, shadow_flags, shadow_bank_select};
      end
      m.p = stack_top;
      {m.w, m.f, m.b} = {w, f, b};
      nq.push_back(m);
      instr_valid = 1;
      @(negedge mclk);
      instr_valid = 0;
    end
    repeat (12) @(negedge mclk);
    chk("notes left", 21'h0, 21'(nq.size()));
    $display("test random mix done");
    end_sim();
  end
endmodule : srr_core_tb_top
bind srr_core srr_core_props i_props (
  .mclk       (mclk),
  .rst        (rst),
  .stack_top  (stack_top),
  .file_rdata (file_rdata),
  .q_phase    (q_phase),
  .file_rd    (file_rd),
  .file_wr    (file_wr),
  .file_wdata (file_wdata),
  .stack_pop  (stack_pop),
  .pc         (pc),
  .flags      (flags),
  .flush      (flush)
);
